// *** src/ffps_pkg.sv ***
/*
 * Shared constants and carrier types for the flyback fault-protection
 * sequencer. Assumes a single 125 MHz system clock.
 */
package ffps_pkg;

	// Clock period in picoseconds.
	localparam int unsigned CLK_PS = 8000;

	// Protection times as printed, each in its own unit.
	localparam int unsigned SURGE_HALT_NS = 200;
	localparam int unsigned SURGE_WIN_MS = 10;
	localparam int unsigned FBSAT_MS = 100;
	localparam int unsigned RESTART_MS = 2500;
	localparam int unsigned BROWN_MS = 100;
	localparam int unsigned CS2_HOLD_MS = 1;
	localparam int unsigned BLANK_MIN_NS = 3000;
	localparam int unsigned STARTER_US = 500;

	// Cycle counts; least times round up, longest times round down.
	localparam int unsigned SURGE_HALT_CYC = (SURGE_HALT_NS * 1000) / CLK_PS;
	localparam int unsigned BLANK_CYC =
		(BLANK_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int unsigned STARTER_CYC = (STARTER_US * 1000) / (CLK_PS / 1000);
	localparam longint unsigned MS_CYC = 64'd1000000000 / CLK_PS;

	// Width of the long protection counters.
	localparam int unsigned TW = 32;

	// Sequencer modes.
	typedef enum logic [2:0] {
		FFPS_ACTIVE = 3'b000,
		FFPS_STOP_SURGE = 3'b001,
		FFPS_STOP_CS2 = 3'b010,
		FFPS_LOWC_SURGE = 3'b011,
		FFPS_LOWC_TIMED = 3'b100
	} ffps_mode_t;

	// Comparator results from the power stage.
	typedef struct packed {
		logic surge_hi;
		logic fb_sat;
		logic zcd_armed;
		logic clamp_hi;
		logic cs2_trip;
		logic vcc_low2v;
		logic gate_on;
	} ffps_sense_t;

	// Controls towards the gate driver and start-up unit.
	typedef struct packed {
		logic gate_enable;
		logic starter_hold;
		logic hv_startup_on;
		logic hv_safe_current;
		logic low_consumption;
		logic stop_mode;
	} ffps_ctrl_t;

endpackage

// *** src/ffps_timer.sv ***
/*
 * Resettable elapsed-time counter used by every protection timer.
 * Assumes the caller holds run high while the condition stands.
 */
`timescale 1ns/1ps
module ffps_timer #(
	parameter logic [ffps_pkg::TW-1:0] LIMIT = 32'h0000_0001
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic run,
	output logic done
);

	logic [ffps_pkg::TW-1:0] cnt_q;

	// Count while running; a dropped condition returns to zero.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else if (!run) begin
			cnt_q <= '0;
		end else if (cnt_q < LIMIT) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Done once the limit has been reached.
	assign done = run && (cnt_q >= LIMIT);

endmodule

// *** src/ffps_seq.sv ***
/*
 * Fault-protection sequencer for a quasi-resonant flyback controller.
 * Assumes comparator results arrive asynchronously and that the reset
 * is the undervoltage lockout of the supply.
 */
// Operation
// - Surge on start-up pin halts gate switching within 200 ns.
// - A tripped input overvoltage guard enters stop mode.
// - Surge clearing within 10 ms resumes switching at once.
// - Surge beyond 10 ms enters low-consumption until the pin drops.
// - Feedback saturated over 100 ms stops into low-consumption.
// - Feedback-saturation shutdown auto-restarts after 2.5 s.
// - Arming is checked only after the minimum blanking interval.
// - Unarmed at the check invokes a 500 us starter timeout.
// - Brownout is judged only during the on-time.
// - Clamp current above 100 uA gives a per-cycle indication.
// - The brownout timer clears whenever clamp current is high during the on-time.
// - Brownout timer reaching 100 ms stops in low-consumption.
// - Brownout shutdown auto-restarts after 2.5 s.
// - Second-level current trip suspends switching 1 ms, then restarts.
// - That suspension is a stop-mode variant, not low-consumption.
// - Supply below 2 V selects the reduced start-up charge current.
// - Minimum blanking lasts 3 us from turn-off.
`timescale 1ns/1ps
module ffps_seq #(
	parameter logic [ffps_pkg::TW-1:0] SURGE_WIN_CYC =
		ffps_pkg::TW'(ffps_pkg::SURGE_WIN_MS * ffps_pkg::MS_CYC),
	parameter logic [ffps_pkg::TW-1:0] FBSAT_CYC =
		ffps_pkg::TW'(ffps_pkg::FBSAT_MS * ffps_pkg::MS_CYC),
	parameter logic [ffps_pkg::TW-1:0] BROWN_CYC =
		ffps_pkg::TW'(ffps_pkg::BROWN_MS * ffps_pkg::MS_CYC),
	parameter logic [ffps_pkg::TW-1:0] RESTART_CYC =
		ffps_pkg::TW'(ffps_pkg::RESTART_MS * ffps_pkg::MS_CYC),
	parameter logic [ffps_pkg::TW-1:0] CS2_CYC =
		ffps_pkg::TW'(ffps_pkg::CS2_HOLD_MS * ffps_pkg::MS_CYC)
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire ffps_pkg::ffps_sense_t sense,
	output ffps_pkg::ffps_ctrl_t ctrl,
	output logic brownout_flag,
	output logic fb_sat_flag
);

	localparam logic [ffps_pkg::TW-1:0] BLANK_LIM =
		ffps_pkg::TW'(ffps_pkg::BLANK_CYC);
	localparam logic [ffps_pkg::TW-1:0] STARTER_LIM =
		ffps_pkg::TW'(ffps_pkg::STARTER_CYC);
	localparam int HALT_MAX = ffps_pkg::SURGE_HALT_CYC;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers: three stages, change taken when 2 and 3 agree.

	localparam int NS = $bits(ffps_pkg::ffps_sense_t);
	ffps_pkg::ffps_sense_t s1_q, s2_q, s3_q, sy_q;

	// Shift the raw comparator results through three flops.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= sense;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Accept a new level per bit only when the last two stages agree.
	wire [NS-1:0] sy_d;
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_agree
			assign sy_d[gi] = (s2_q[gi] == s3_q[gi]) ?
				s3_q[gi] : sy_q[gi];
		end
	endgenerate

	// Register the agreed levels in one process, so one driver owns them.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sy_q <= '0;
		end else begin
			sy_q <= sy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Protection timers.

	ffps_pkg::ffps_mode_t mode_q;
	logic surge_done, fbsat_done, brown_done, restart_done, cs2_done;
	logic blank_done, starter_done;
	logic in_lowc_timed, in_cs2, in_surge_stop;
	logic gate_off_q, armed_q, starter_q, clamp_seen_q, gate_prev_q;

	assign in_surge_stop = (mode_q == ffps_pkg::FFPS_STOP_SURGE);
	assign in_lowc_timed = (mode_q == ffps_pkg::FFPS_LOWC_TIMED);
	assign in_cs2 = (mode_q == ffps_pkg::FFPS_STOP_CS2);

	// Surge window runs only while the overvoltage is present.
	ffps_timer #(.LIMIT(SURGE_WIN_CYC)) u_surge (
		.mclk(mclk), .rst_b(rst_b),
		.run(in_surge_stop && sy_q.surge_hi), .done(surge_done));

	// Feedback saturation must be continuous to count.
	ffps_timer #(.LIMIT(FBSAT_CYC)) u_fbsat (
		.mclk(mclk), .rst_b(rst_b),
		.run(sy_q.fb_sat && (mode_q == ffps_pkg::FFPS_ACTIVE)),
		.done(fbsat_done));

	// Brownout timer runs in active mode, zeroed by a high clamp reading during the on-time.
	ffps_timer #(.LIMIT(BROWN_CYC)) u_brown (
		.mclk(mclk), .rst_b(rst_b),
		.run(!clamp_seen_q && (mode_q == ffps_pkg::FFPS_ACTIVE)),
		.done(brown_done));

	// Auto-restart wait in timed low-consumption.
	ffps_timer #(.LIMIT(RESTART_CYC)) u_restart (
		.mclk(mclk), .rst_b(rst_b),
		.run(in_lowc_timed), .done(restart_done));

	// Second-level current suspension.
	ffps_timer #(.LIMIT(CS2_CYC)) u_cs2 (
		.mclk(mclk), .rst_b(rst_b),
		.run(in_cs2), .done(cs2_done));

	// Minimum blanking, measured from gate turn-off.
	ffps_timer #(.LIMIT(BLANK_LIM)) u_blank (
		.mclk(mclk), .rst_b(rst_b),
		.run(gate_off_q), .done(blank_done));

	// Starter timeout while the valley check found no arming.
	ffps_timer #(.LIMIT(STARTER_LIM)) u_starter (
		.mclk(mclk), .rst_b(rst_b),
		.run(starter_q), .done(starter_done));

	////////////////////////////////////////////////////////////////////////
	// Switching-cycle tracking: blanking, arming check and clamp sampling.

	// Remember the gate level to find the turn-off edge.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gate_prev_q <= 1'b0;
		end else begin
			gate_prev_q <= sy_q.gate_on;
		end
	end

	// Off-time flag: set at turn-off, cleared at the next turn-on.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gate_off_q <= 1'b0;
			armed_q <= 1'b0;
		end else if (sy_q.gate_on) begin
			gate_off_q <= 1'b0;
			armed_q <= 1'b0;
		end else if (gate_prev_q) begin
			gate_off_q <= 1'b1;
		end else if (blank_done && !armed_q) begin
			armed_q <= 1'b1;
		end
	end

	// Starter hold launches once at the check when the valley is unarmed.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			starter_q <= 1'b0;
		end else if (starter_done || sy_q.gate_on) begin
			starter_q <= 1'b0;
		end else if (blank_done && !armed_q && !sy_q.zcd_armed) begin
			starter_q <= 1'b1;
		end
	end

	// Clamp current is only sampled while the switch conducts.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			clamp_seen_q <= 1'b0;
		end else begin
			clamp_seen_q <= sy_q.gate_on && sy_q.clamp_hi;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode sequencer.

	logic surge_now;
	assign surge_now = sy_q.surge_hi;

	// Low-consumption outcomes are checked before timed stops.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= ffps_pkg::FFPS_ACTIVE;
		end else begin
			case (mode_q)
				ffps_pkg::FFPS_ACTIVE: begin
					if (fbsat_done || brown_done) begin
						mode_q <= ffps_pkg::FFPS_LOWC_TIMED;
					end else if (surge_now) begin
						mode_q <= ffps_pkg::FFPS_STOP_SURGE;
					end else if (sy_q.cs2_trip) begin
						mode_q <= ffps_pkg::FFPS_STOP_CS2;
					end
				end
				ffps_pkg::FFPS_STOP_SURGE: begin
					if (!surge_now) begin
						mode_q <= ffps_pkg::FFPS_ACTIVE;
					end else if (surge_done) begin
						mode_q <= ffps_pkg::FFPS_LOWC_SURGE;
					end
				end
				ffps_pkg::FFPS_STOP_CS2: begin
					if (surge_now) begin
						mode_q <= ffps_pkg::FFPS_STOP_SURGE;
					end else if (cs2_done) begin
						mode_q <= ffps_pkg::FFPS_ACTIVE;
					end
				end
				ffps_pkg::FFPS_LOWC_SURGE: begin
					if (!surge_now) begin
						mode_q <= ffps_pkg::FFPS_ACTIVE;
					end
				end
				ffps_pkg::FFPS_LOWC_TIMED: begin
					if (restart_done) begin
						mode_q <= ffps_pkg::FFPS_ACTIVE;
					end
				end
				default: begin
					mode_q <= ffps_pkg::FFPS_ACTIVE;
				end
			endcase
		end
	end

	// Remember which fault caused the timed shutdown.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			brownout_flag <= 1'b0;
			fb_sat_flag <= 1'b0;
		end else if (mode_q == ffps_pkg::FFPS_ACTIVE) begin
			brownout_flag <= brown_done;
			fb_sat_flag <= fbsat_done && !brown_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs to gate driver and start-up unit.

	// True in either low-consumption mode.
	function automatic logic is_lowc(input ffps_pkg::ffps_mode_t m);
		return (m == ffps_pkg::FFPS_LOWC_SURGE) ||
			(m == ffps_pkg::FFPS_LOWC_TIMED);
	endfunction

	// Gate enable drops the cycle after a surge is accepted.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= '0;
		end else begin
			ctrl.gate_enable <= (mode_q == ffps_pkg::FFPS_ACTIVE) &&
				!surge_now && !sy_q.cs2_trip;
			ctrl.starter_hold <= starter_q;
			ctrl.hv_startup_on <= is_lowc(mode_q);
			ctrl.hv_safe_current <= sy_q.vcc_low2v;
			ctrl.low_consumption <= is_lowc(mode_q);
			ctrl.stop_mode <= in_surge_stop || in_cs2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.

	sequence surge_seen_s;
		sy_q.surge_hi && mode_q == ffps_pkg::FFPS_ACTIVE;
	endsequence

	surge_halt_a: assert property (@(posedge mclk) disable iff (!rst_b)
		surge_seen_s |-> ##[1:HALT_MAX] !ctrl.gate_enable)
		else $error("Gate not halted after surge.");

	surge_stop_a: assert property (@(posedge mclk) disable iff (!rst_b)
		(surge_seen_s and (!fbsat_done && !brown_done)) |=> in_surge_stop)
		else $error("Surge did not enter stop mode.");

	surge_resume_a: assert property (@(posedge mclk) disable iff (!rst_b)
		in_surge_stop && !surge_now |=> mode_q == ffps_pkg::FFPS_ACTIVE)
		else $error("Switching not resumed after short surge.");

	surge_lowc_a: assert property (@(posedge mclk) disable iff (!rst_b)
		in_surge_stop && surge_done |=> ##1 ctrl.low_consumption)
		else $error("Long surge did not reach low consumption.");

	cs2_mode_a: assert property (@(posedge mclk) disable iff (!rst_b)
		in_cs2 |=> !ctrl.low_consumption && ctrl.stop_mode)
		else $error("Current trip stop shows wrong mode.");

	lowc_prio_a: assert property (@(posedge mclk) disable iff (!rst_b)
		mode_q == ffps_pkg::FFPS_ACTIVE && brown_done |=> in_lowc_timed)
		else $error("Low consumption lost priority.");

	restart_a: assert property (@(posedge mclk) disable iff (!rst_b)
		in_lowc_timed && restart_done |=> mode_q == ffps_pkg::FFPS_ACTIVE)
		else $error("Auto-restart missing.");

	safe_charge_a: assert property (@(posedge mclk) disable iff (!rst_b)
		sy_q.vcc_low2v [*2] |-> ##1 ctrl.hv_safe_current)
		else $error("Safe charge current not selected.");

	clamp_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
		clamp_seen_q |-> $past(sy_q.gate_on))
		else $error("Clamp sampled outside on-time.");

endmodule

// *** tb/ffps_stage.sv ***
/*
 * Behavioural flyback power stage seen through its comparators.
 * Assumes the bench steers line level, output short and forced turn-on.
 */
`timescale 1ns/1ps
module ffps_stage (
	input wire logic mclk,
	input wire ffps_pkg::ffps_ctrl_t ctrl,
	input wire logic line_ok,
	input wire logic clamp_off,
	input wire logic short_out,
	input wire logic force_on,
	output logic gate_on,
	output logic zcd_armed,
	output logic clamp_hi
);
	logic [7:0] cnt;

	////////////////////////////////////////////////////////////////////
	// Switching cycle: 16 cycles on, at least 32 off, then a valley.
	initial begin
		gate_on = 1'b0;
		cnt = 8'h00;
	end
	always @(negedge mclk) begin
		if (gate_on) begin
			cnt <= cnt + 8'h01;
			if (cnt == 8'h0F || !ctrl.gate_enable) begin
				gate_on <= 1'b0;
				cnt <= 8'h00;
			end
		end else begin
			if (cnt != 8'hFF)
				cnt <= cnt + 8'h01;
			if (force_on || (ctrl.gate_enable && !ctrl.starter_hold &&
				!ctrl.low_consumption && !short_out && cnt >= 8'h1F)) begin
				gate_on <= 1'b1;
				cnt <= 8'h00;
			end
		end
	end

	// A shorted output never arms; clamp follows line_ok while on and clamp_off while off.
	assign zcd_armed = !gate_on && !short_out;
	assign clamp_hi = gate_on ? line_ok : clamp_off;
endmodule

// *** tb/ffps_seq_tb.sv ***
/*
 * Self-checking bench for the fault-protection sequencer.
 * Assumes the design's own assertions guard the cycle-level rules.
 */
`timescale 1ns/1ps
module ffps_seq_tb;
	localparam int SW = 40, FS = 60, BR = 600, RS = 100, CS = 30;
	localparam int SM = 0, LC = 1, SF = 2, HV = 3, HD = 4, GE = 5;
	localparam int FF = 6, BF = 7;
	logic mclk = 1'b0, rst_b = 1'b0, surge = 1'b0, fbsat = 1'b0;
	logic cs2 = 1'b0, vlow = 1'b0, line_ok = 1'b1, clamp_off = 1'b0;
	logic short_out = 1'b0, force_on = 1'b0;
	logic gate_on, zcd_armed, clamp_hi, bo_flag, fs_flag;
	ffps_pkg::ffps_sense_t sense;
	ffps_pkg::ffps_ctrl_t ctrl;
	logic [7:0] obs;
	int n_errors = 0, checks = 0, cyc = 0, seed = 32'hBBBD5D61, r;

	////////////////////////////////////////////////////////////////////
	// Clock, sense assembly and the watched output vector.
	always #4 mclk = ~mclk;
	assign sense = {surge, fbsat, zcd_armed, clamp_hi, cs2, vlow, gate_on};
	assign obs = {bo_flag, fs_flag, ctrl};

	ffps_seq #(.SURGE_WIN_CYC(32'(SW)), .FBSAT_CYC(32'(FS)),
		.BROWN_CYC(32'(BR)), .RESTART_CYC(32'(RS)), .CS2_CYC(32'(CS))
	) u_ffps_seq (.mclk(mclk), .rst_b(rst_b), .sense(sense),
		.ctrl(ctrl), .brownout_flag(bo_flag), .fb_sat_flag(fs_flag));

	ffps_stage u_ffps_stage (.mclk(mclk), .ctrl(ctrl), .line_ok(line_ok),
		.clamp_off(clamp_off), .short_out(short_out),
		.force_on(force_on), .gate_on(gate_on), .zcd_armed(zcd_armed),
		.clamp_hi(clamp_hi));

	////////////////////////////////////////////////////////////////////
	// Shared tasks for comparing, waiting and closing the run.
	task check(input string nm, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task give_verdict;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task wait_bit(input int b, input logic v, input int lo, hi,
		input string nm);
		int n;
		n = 0;
		while (obs[b] !== v && n <= hi) begin
			@(negedge mclk);
			n++;
		end
		check(nm, 32'(n >= lo && n <= hi), 32'h1);
	endtask

	task cyc_n(input int k);
		repeat (k) @(negedge mclk);
	endtask

	// Cuts a hung run short.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			give_verdict;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Main sequence of scenarios.
	initial begin
		cyc_n(20);
		check("reset_out", 32'(obs), 32'h0);
		rst_b = 1'b1;
		wait_bit(GE, 1, 0, 20, "start_gate");
		for (int i = 0; i < 4; i++) begin
			r = $unsigned($random(seed)) % 20;
			surge = 1'b1;
			wait_bit(GE, 0, 1, 25, "surge_halt");
			wait_bit(SM, 1, 0, 3, "surge_stop");
			cyc_n(5 + r);
			surge = 1'b0;
			wait_bit(GE, 1, 1, 12, "surge_resume");
			check("surge_lowc", 32'(obs[LC]), 32'h0);
			vlow = r[0];
			wait_bit(SF, r[0], 0, 8, "safe_charge");
		end
		surge = 1'b1;
		cyc_n(SW + 20);
		check("long_lowc", 32'(obs[LC]), 32'h1);
		check("long_hv", 32'(obs[HV]), 32'h1);
		surge = 1'b0;
		wait_bit(LC, 0, 1, 12, "long_exit");
		fbsat = 1'b1;
		cyc_n(FS - 15);
		fbsat = 1'b0;
		cyc_n(10);
		fbsat = 1'b1;
		cyc_n(FS - 15);
		check("fb_cleared", 32'(obs[LC]), 32'h0);
		wait_bit(LC, 1, 1, 25, "fb_trip");
		check("fb_flag", 32'(obs[FF]), 32'h1);
		fbsat = 1'b0;
		cyc_n(RS - 20);
		check("fb_wait", 32'(obs[LC]), 32'h1);
		check("fb_hv", 32'(obs[HV]), 32'h1);
		wait_bit(LC, 0, 1, 30, "fb_restart");
		wait_bit(GE, 1, 0, 5, "fb_gate");
		cyc_n(60);
		cs2 = 1'b1;
		wait_bit(GE, 0, 1, 25, "cs2_halt");
		cs2 = 1'b0;
		wait_bit(SM, 1, 0, 3, "cs2_stop");
		check("cs2_lowc", 32'(obs[LC]), 32'h0);
		wait_bit(GE, 1, CS - 3, CS + 5, "cs2_resume");
		line_ok = 1'b0;
		clamp_off = 1'b1;
		wait_bit(LC, 1, BR - 60, BR + 20, "brown_trip");
		check("brown_flag", 32'(obs[BF]), 32'h1);
		cs2 = 1'b1;
		cyc_n(10);
		check("prio_lowc", 32'(obs[LC]), 32'h1);
		check("prio_stop", 32'(obs[SM]), 32'h0);
		cs2 = 1'b0;
		line_ok = 1'b1;
		clamp_off = 1'b0;
		wait_bit(LC, 0, RS - 25, RS + 10, "brown_restart");
		cyc_n(100);
		while (gate_on !== 1'b1) @(negedge mclk);
		short_out = 1'b1;
		while (gate_on !== 1'b0) @(negedge mclk);
		wait_bit(HD, 1, 372, 392, "starter_on");
		check("starter_gate", 32'(obs[GE]), 32'h1);
		force_on = 1'b1;
		repeat (2) @(negedge mclk);
		force_on = 1'b0;
		short_out = 1'b0;
		wait_bit(HD, 0, 0, 10, "starter_off");
		give_verdict;
	end
endmodule
